// ==== tccu_params.svh ====
// constants for the timer capture/compare unit
// How it works
// - capture copies 16-bit timer into holding register
// - events: falling, rising, 4th rising, 16th rising
// - mode field in control bits 3:0 picks behaviour
// - capture sets flag bit 2; software clears
// - new capture overwrites unread holding value
// - mode change may give spurious interrupt
// - prescaler counter zero when off or not capturing
// - prescaler switch keeps count, may interrupt
// - compare holding register against timer continuously
// - match drives pin high, low or unchanged
// - compare match sets the flag, except in the cycle after a special event trigger
// - control write of zero clears compare latch
// - software-interrupt sub-mode leaves pin alone
// - special event pulse resets the timer
// - special event starts conversion if converter enabled
// - interrupt needs unit, peripheral and global enables
`ifndef TCCU_PARAMS_SVH
`define TCCU_PARAMS_SVH
`define TCCU_OFF_FLAGS 12'h00c
`define TCCU_OFF_HOLD_LO 12'h015
`define TCCU_OFF_HOLD_HI 12'h016
`define TCCU_OFF_CTRL 12'h017
`define TCCU_OFF_ENABLES 12'h08c
`define TCCU_OFF_CORE_IE 12'h100
`define TCCU_ADDR(idx) ((idx) << 2)
`define TCCU_FLAG_BIT 2
`define TCCU_CTRL_RESET 8'h00
`define TCCU_FLAGS_MASK 8'h4f
`define TCCU_CTRL_MASK 8'h3f
`define TCCU_DIV4 5'h04
`define TCCU_DIV16 5'h10
`endif

// ==== tccu_pkg.sv ====
// types for the timer capture/compare unit
package tccu_pkg;
  typedef enum logic [3:0] {
    TCCU_OFF = 4'h0,
    TCCU_CAP_FALL = 4'h4,
    TCCU_CAP_RISE = 4'h5,
    TCCU_CAP_RISE4 = 4'h6,
    TCCU_CAP_RISE16 = 4'h7,
    TCCU_CMP_SET = 4'h8,
    TCCU_CMP_CLR = 4'h9,
    TCCU_CMP_SWI = 4'ha,
    TCCU_CMP_SPECIAL = 4'hb
  } tccu_mode_t;
endpackage : tccu_pkg

// ==== tccu_evt_if.sv ====
// event signals between the edge detector and the core
`timescale 1ns/1ps
`default_nettype none
interface tccu_evt_if;
  logic rise;
  logic fall;
  logic level;
  modport src (output rise, output fall, output level);
  modport dst (input rise, input fall, input level);
endinterface : tccu_evt_if
`default_nettype wire

// ==== tccu_edge.sv ====
// pin synchroniser and edge detector
`timescale 1ns/1ps
`default_nettype none
module tccu_edge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_in,
  tccu_evt_if.src evt
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end
  assign evt.rise = sync_reg & ~last_reg;
  assign evt.fall = ~sync_reg & last_reg;
  assign evt.level = sync_reg;
  edge_single_a: assert property (@(posedge pclk) disable iff (!presetn)
    evt.rise |=> !evt.rise) else $error("rise pulse longer than one cycle");
endmodule : tccu_edge
`default_nettype wire

// ==== tccu_top.sv ====
// capture/compare unit with apb register access
`timescale 1ns/1ps
`default_nettype none
`include "tccu_params.svh"
module tccu_top #(
  parameter int TW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [TW-1:0] timer_count_pair,
  input wire logic adc_enabled,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  input wire logic pin_dir_output,
  output logic timer_reset,
  output logic adc_start,
  output logic irq
);
  initial begin
    if (TW != 16) $error("timer width must be 16");
  end
  tccu_evt_if evt ();
  tccu_edge u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(pin_in),
    .evt(evt)
  );
  logic [7:0] ctrl_reg;
  logic [15:0] hold_reg;
  logic flag_reg;
  logic unit_ie_reg;
  logic [7:0] flags_other_reg;
  logic [7:0] ena_other_reg;
  logic peripheral_irq_master_enable_reg;
  logic gie_reg;
  logic [4:0] pre_reg;
  logic [4:0] pre_next;
  logic cmp_latch_reg;
  logic trig_reg;
  logic [31:0] prdata_reg;
  wire logic [3:0] mode = ctrl_reg[3:0];
  wire logic is_cap = (mode[3:2] == 2'b01);
  wire logic is_cmp = (mode[3:2] == 2'b10);
  wire logic access = psel & penable;
  wire logic wr = access & pwrite;
  wire logic hit_flags = paddr == `TCCU_ADDR(`TCCU_OFF_FLAGS);
  wire logic hit_lo = paddr == `TCCU_ADDR(`TCCU_OFF_HOLD_LO);
  wire logic hit_hi = paddr == `TCCU_ADDR(`TCCU_OFF_HOLD_HI);
  wire logic hit_ctrl = paddr == `TCCU_ADDR(`TCCU_OFF_CTRL);
  wire logic hit_ena = paddr == `TCCU_ADDR(`TCCU_OFF_ENABLES);
  wire logic hit_core = paddr == `TCCU_ADDR(`TCCU_OFF_CORE_IE);
  wire logic mapped = hit_flags | hit_lo | hit_hi | hit_ctrl | hit_ena | hit_core;
  wire logic wr_ctrl = wr & hit_ctrl;
  // prescaler: counts rising edges in /4 and /16 modes
  wire logic [4:0] div = (mode == tccu_pkg::TCCU_CAP_RISE16) ? `TCCU_DIV16 : `TCCU_DIV4;
  wire logic pre_mode = (mode == tccu_pkg::TCCU_CAP_RISE4) |
                        (mode == tccu_pkg::TCCU_CAP_RISE16);
  wire logic pre_wrap = pre_mode & evt.rise & (pre_reg + 5'h01 >= div);
  wire logic cap_evt = ((mode == tccu_pkg::TCCU_CAP_FALL) & evt.fall) |
                       ((mode == tccu_pkg::TCCU_CAP_RISE) & evt.rise) |
                       pre_wrap;
  wire logic match = is_cmp & (hold_reg == timer_count_pair);
  wire logic cmp_evt = match & ~trig_reg;
  wire logic set_flag = cap_evt | cmp_evt;
  always_comb begin
    pre_next = pre_reg;
    if (!is_cap) pre_next = 5'h00;
    else if (pre_wrap) pre_next = 5'h00;
    else if (pre_mode & evt.rise) pre_next = pre_reg + 5'h01;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `TCCU_CTRL_RESET;
      pre_reg <= 5'h00;
      flag_reg <= 1'b0;
      unit_ie_reg <= 1'b0;
      flags_other_reg <= 8'h00;
      ena_other_reg <= 8'h00;
      peripheral_irq_master_enable_reg <= 1'b0;
      gie_reg <= 1'b0;
      hold_reg <= 16'h0000;
      cmp_latch_reg <= 1'b0;
      trig_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      if (wr_ctrl) ctrl_reg <= pwdata[7:0] & `TCCU_CTRL_MASK;
      if (cap_evt) hold_reg <= timer_count_pair;
      else if (wr & hit_lo) hold_reg[7:0] <= pwdata[7:0];
      else if (wr & hit_hi) hold_reg[15:8] <= pwdata[7:0];
      // set wins over a software clear in the same cycle
      if (set_flag) flag_reg <= 1'b1;
      else if (wr & hit_flags) flag_reg <= pwdata[`TCCU_FLAG_BIT];
      if (wr & hit_flags) flags_other_reg <= pwdata[7:0] & `TCCU_FLAGS_MASK;
      if (wr & hit_ena) begin
        unit_ie_reg <= pwdata[`TCCU_FLAG_BIT];
        ena_other_reg <= pwdata[7:0] & `TCCU_FLAGS_MASK;
      end
      if (wr & hit_core) begin
        gie_reg <= pwdata[7];
        peripheral_irq_master_enable_reg <= pwdata[6];
      end
      if (wr_ctrl && pwdata[7:0] == 8'h00) cmp_latch_reg <= 1'b0;
      else if (cmp_evt && mode == tccu_pkg::TCCU_CMP_SET) cmp_latch_reg <= 1'b1;
      else if (cmp_evt && mode == tccu_pkg::TCCU_CMP_CLR) cmp_latch_reg <= 1'b0;
      // SWI mode leaves the latch as is
      trig_reg <= cmp_evt & (mode == tccu_pkg::TCCU_CMP_SPECIAL);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_reg <= 32'h00000000;
    else if (psel & ~penable & ~pwrite) begin
      prdata_reg <= 32'h00000000;
      if (hit_flags) prdata_reg[7:0] <= (flags_other_reg & ~8'h04) |
                                        {5'h00, flag_reg, 2'b00};
      if (hit_lo) prdata_reg[7:0] <= hold_reg[7:0];
      if (hit_hi) prdata_reg[7:0] <= hold_reg[15:8];
      if (hit_ctrl) prdata_reg[7:0] <= ctrl_reg;
      if (hit_ena) prdata_reg[7:0] <= (ena_other_reg & ~8'h04) |
                                      {5'h00, unit_ie_reg, 2'b00};
      if (hit_core) prdata_reg[7:0] <= {gie_reg, peripheral_irq_master_enable_reg, 6'h00};
    end
  end
  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  // latch only reaches the pin while software has made it an output
  assign pin_out = cmp_latch_reg;
  assign pin_oe = pin_dir_output;
  assign timer_reset = trig_reg;
  assign adc_start = trig_reg & adc_enabled;
  assign irq = flag_reg & unit_ie_reg & peripheral_irq_master_enable_reg & gie_reg;
  sequence rise_seen;
    evt.rise && mode == tccu_pkg::TCCU_CAP_RISE;
  endsequence
  cap_copies_a: assert property (@(posedge pclk) disable iff (!presetn)
    rise_seen |=> hold_reg == $past(timer_count_pair) && flag_reg)
    else $error("capture did not copy timer");
  pre_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    !is_cap |=> pre_reg == 5'h00) else $error("prescaler not cleared");
  flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    flag_reg && !(wr & hit_flags) |=> flag_reg) else $error("flag lost");
  cmp_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_evt |=> flag_reg) else $error("match did not flag");
  set_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_evt && mode == tccu_pkg::TCCU_CMP_SET && !wr_ctrl |=> pin_out)
    else $error("set on match failed");
  swi_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_evt && mode == tccu_pkg::TCCU_CMP_SWI && !wr_ctrl |=> $stable(pin_out))
    else $error("pin moved in swi mode");
  zero_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl && pwdata[7:0] == 8'h00 |=> !pin_out) else $error("latch not cleared");
  trig_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_evt && mode == tccu_pkg::TCCU_CMP_SPECIAL |=> timer_reset ##1 !timer_reset)
    else $error("special trigger wrong");
  adc_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    adc_start |-> timer_reset && adc_enabled) else $error("adc start ungated");
  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq |-> flag_reg && unit_ie_reg && gie_reg && peripheral_irq_master_enable_reg)
    else $error("irq without enables");
endmodule : tccu_top
`default_nettype wire

// ==== tccu_pin_src.sv ====
// event source model driving the shared pin from the far side
`timescale 1ns/1ps
`default_nettype none
module tccu_pin_src (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [4:0] n,
  output logic pin,
  output logic busy
);
  logic [7:0] cnt_reg;
  // eight cycles per pulse keep every edge well apart for the synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_reg <= 8'h00;
    else if (go && cnt_reg == 8'h00) cnt_reg <= {n, 3'b000};
    else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
  end
  // pin rests low between bursts, as a released input pulled down would
  assign pin = cnt_reg[2];
  assign busy = cnt_reg != 8'h00;
endmodule : tccu_pin_src
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the capture/compare unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, adc_enabled = 0;
  logic pin_dir_output = 0, go = 0, pready, pslverr, pin_in, pin_out, pin_oe;
  logic timer_reset, adc_start, irq, src_pin, busy, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [15:0] timer_count_pair = 16'h0000;
  logic [4:0] n = 5'h00;
  int errors = 0, n_checks = 0;
  always #2.5 pclk = ~pclk;
  assign pin_in = pin_oe ? pin_out : src_pin;
  tccu_top i_tccu_top(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_count_pair(timer_count_pair), .adc_enabled(adc_enabled),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_dir_output(pin_dir_output),
    .timer_reset(timer_reset), .adc_start(adc_start), .irq(irq));
  tccu_pin_src i_tccu_pin_src(.pclk(pclk), .presetn(presetn), .go(go), .n(n),
    .pin(src_pin), .busy(busy));
  task test_done;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, x, s);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    if (k >= 40) begin
      errors++;
      test_done;
    end
    r = prdata; e = pslverr; psel <= 0; penable <= 0;
  endtask : apb
  task pulses(input logic [4:0] k);
    int j;
    go <= 1; n <= k;
    @(posedge pclk);
    go <= 0;
    @(posedge pclk);
    for (j = 0; busy === 1'b1 && j < 200; j++) @(posedge pclk);
    if (j >= 200) begin
      errors++;
      test_done;
    end
    repeat (6) @(posedge pclk);
  endtask : pulses
  // zero the control first so the edge count starts clean
  task cap(input logic [3:0] m, input logic [4:0] k, input logic [15:0] t);
    apb(1, 12'h05c, 32'h0); apb(1, 12'h05c, {28'h0, m}); apb(1, 12'h030, 32'h0);
    timer_count_pair <= t;
    pulses(k - 5'h01);
    apb(0, 12'h030, 32'h0); chk("early flag", r[2], 0);
    pulses(5'h01);
    apb(0, 12'h030, 32'h0); chk("cap flag", r[2], 1);
    apb(0, 12'h054, 32'h0); chk("hold lo", r, {24'h0, t[7:0]});
    apb(0, 12'h058, 32'h0); chk("hold hi", r, {24'h0, t[15:8]});
  endtask : cap
  task cmp(input logic [3:0] m, input logic p0, input logic p1);
    timer_count_pair <= 16'h0000;
    apb(1, 12'h05c, {28'h0, m}); apb(1, 12'h030, 32'h0);
    @(negedge pclk);
    chk("pin before", pin_out, p0);
    @(posedge pclk);
    timer_count_pair <= 16'h0040;
    repeat (3) @(posedge pclk);
    timer_count_pair <= 16'h0000;
    @(negedge pclk);
    chk("pin after", pin_out, p1);
    apb(0, 12'h030, 32'h0); chk("cmp flag", r[2], 1);
  endtask : cmp
  task special;
    @(posedge pclk);
    adc_enabled <= 1;
    apb(1, 12'h05c, 32'h0000000b);
    timer_count_pair <= 16'h0040;
    @(posedge pclk);
    @(negedge pclk);
    chk("trigger", timer_reset, 1);
    chk("conversion", adc_start, 1);
    @(posedge pclk);
    timer_count_pair <= 16'h0000;
  endtask : special
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h030, 32'h0); chk("flags rst", r, 0);
    apb(0, 12'h05c, 32'h0); chk("ctrl rst", r, 0);
    apb(0, 12'h230, 32'h0); chk("enables rst", r, 0);
    apb(0, 12'h044, 32'h0); chk("unmapped err", e, 1);
    cap(4'h4, 5'h01, 16'h1111);
    cap(4'h6, 5'h04, 16'h5678);
    cap(4'h7, 5'h10, 16'h9abc);
    cap(4'h5, 5'h01, 16'h1234);
    timer_count_pair <= 16'habcd;
    pulses(5'h01);
    apb(0, 12'h054, 32'h0); chk("overwrite", r, 32'hcd);
    apb(1, 12'h230, 32'h4); apb(1, 12'h400, 32'hc0);
    @(negedge pclk);
    chk("irq on", irq, 1);
    apb(1, 12'h400, 32'h80);
    @(negedge pclk);
    chk("irq masked", irq, 0);
    @(posedge pclk);
    pin_dir_output <= 1;
    apb(1, 12'h054, 32'h40); apb(1, 12'h058, 32'h0); apb(1, 12'h05c, 32'h0);
    cmp(4'h8, 0, 1);
    cmp(4'ha, 1, 1);
    cmp(4'h9, 1, 0);
    cmp(4'h8, 0, 1);
    apb(1, 12'h05c, 32'h0);
    @(negedge pclk);
    chk("latch cleared", pin_out, 0);
    special;
    test_done;
  end
endmodule : tb
`default_nettype wire
